// ---- rtc_pkg.sv ----
package rtc_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned XTAL_HZ = 32768;
  localparam int unsigned TICK_HZ = 1;
  localparam int unsigned PRESCALE_DIV = XTAL_HZ / TICK_HZ;
  localparam int unsigned PRE_W = 16;
  localparam int unsigned SEC_W = 6;
  localparam int unsigned MIN_W = 6;
  localparam int unsigned HOUR_W = 5;
  localparam int unsigned DAY_W = 15;
  localparam int unsigned SW_W = 16;
  localparam logic [SEC_W-1:0] SEC_MAX = 6'h3B;
  localparam logic [MIN_W-1:0] MIN_MAX = 6'h3B;
  localparam logic [HOUR_W-1:0] HOUR_MAX = 5'h17;
  localparam int unsigned TOD_SEC_LSB = 0;
  localparam int unsigned TOD_MIN_LSB = 8;
  localparam int unsigned TOD_HOUR_LSB = 16;
  localparam int unsigned SW_RUN_BIT = 16;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_TIME = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_DAY = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_AL0_TIME = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_AL1_TIME = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_AL1_DAY = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_SW = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_STAT = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_CLR = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_EN = 6'h24;
  localparam int unsigned EV_SEC = 0;
  localparam int unsigned EV_MIN = 1;
  localparam int unsigned EV_HOUR = 2;
  localparam int unsigned EV_DAY = 3;
  localparam int unsigned EV_AL0 = 4;
  localparam int unsigned EV_AL1 = 5;
  localparam int unsigned EV_SW = 6;
  localparam int unsigned EV_W = 7;
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [HOUR_W-1:0] hour;
    logic [MIN_W-1:0] min;
    logic [SEC_W-1:0] sec;
  } tod_s;
  typedef struct packed {
    logic [DAY_W-1:0] day;
    tod_s tod;
  } stamp_s;
endpackage : rtc_pkg

// ---- rtc_calendar_alarm_stopwatch.sv ----
// Notes on behaviour
// - crystal edges are prescaled into a one second tick driving every counter.
// - seconds wrap after sixty; each wrap advances minutes, which wrap after sixty.
// - minutes wrap advances hours modulo 24; hours wrap advances a 15-bit day count.
// - alarm match raises an alarm interrupt when that alarm is enabled.
// - alarm zero compares time of day; alarm one compares day and time.
// - stopwatch loads a written value and counts down once per second.
// - stopwatch underflow raises the stopwatch interrupt when enabled.
// - selectable periodic interrupts on second, minute, hour and day rollover.
// - calibration pin toggles from the prescaled crystal, one hertz square wave.
// - prescaler and counters keep running independent of processor low power.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module rtc_calendar_alarm_stopwatch #(
  parameter int unsigned PRESCALE_DIV = rtc_pkg::PRESCALE_DIV
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // crystal clock pin, sampled
  input wire logic xtal_in,
  // axi4-lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // outputs
  output logic irq,
  output logic one_hz_calib_out
);
  localparam logic [rtc_pkg::PRE_W-1:0] PRE_LAST = rtc_pkg::PRE_W'(PRESCALE_DIV - 1);
  localparam logic [rtc_pkg::PRE_W-1:0] PRE_HALF = rtc_pkg::PRE_W'(PRESCALE_DIV / 2 - 1);

  logic x1_q, x2_q, x3_q, xf_q;
  logic xf_d, xtal_rise;
  logic [rtc_pkg::PRE_W-1:0] pre_q, pre_d;
  logic calib_q, calib_d, run_q, run_d;
  rtc_pkg::stamp_s now_q, now_d;
  rtc_pkg::tod_s al0_q, al0_d;
  rtc_pkg::stamp_s al1_q, al1_d;
  logic [rtc_pkg::SW_W-1:0] sw_q, sw_d;
  logic sw_run_q, sw_run_d;
  logic [rtc_pkg::EV_W-1:0] stat_q, stat_d, en_q, en_d, ev, clr;
  logic irq_q, irq_d, tick, half, wr_fire;
  logic awready_q, awready_d, wready_q, wready_d, aw_have_q, aw_have_d;
  logic w_have_q, w_have_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [rtc_pkg::ADDR_W-1:0] wa_q, wa_d;
  logic [31:0] wd_q, wd_d, rdata_q, rdata_d, wv;
  logic [3:0] ws_q, ws_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  function automatic logic [31:0] tod_word(input rtc_pkg::tod_s t);
    logic [31:0] r;
    r = '0;
    r[rtc_pkg::TOD_SEC_LSB +: rtc_pkg::SEC_W] = t.sec;
    r[rtc_pkg::TOD_MIN_LSB +: rtc_pkg::MIN_W] = t.min;
    r[rtc_pkg::TOD_HOUR_LSB +: rtc_pkg::HOUR_W] = t.hour;
    return r;
  endfunction : tod_word

  function automatic rtc_pkg::tod_s word_tod(input logic [31:0] w);
    rtc_pkg::tod_s t;
    t.sec = w[rtc_pkg::TOD_SEC_LSB +: rtc_pkg::SEC_W];
    t.min = w[rtc_pkg::TOD_MIN_LSB +: rtc_pkg::MIN_W];
    t.hour = w[rtc_pkg::TOD_HOUR_LSB +: rtc_pkg::HOUR_W];
    return t;
  endfunction : word_tod

  function automatic logic [31:0] reg_read(input logic [rtc_pkg::ADDR_W-1:0] a);
    logic [31:0] r;
    r = '0;
    unique case (a)
      rtc_pkg::OFS_CTRL: r[rtc_pkg::CTRL_RUN] = run_q;
      rtc_pkg::OFS_TIME: r = tod_word(now_q.tod);
      rtc_pkg::OFS_DAY: r[rtc_pkg::DAY_W-1:0] = now_q.day;
      rtc_pkg::OFS_AL0_TIME: r = tod_word(al0_q);
      rtc_pkg::OFS_AL1_TIME: r = tod_word(al1_q.tod);
      rtc_pkg::OFS_AL1_DAY: r[rtc_pkg::DAY_W-1:0] = al1_q.day;
      rtc_pkg::OFS_SW:
      begin
        r[rtc_pkg::SW_W-1:0] = sw_q;
        r[rtc_pkg::SW_RUN_BIT] = sw_run_q;
      end
      rtc_pkg::OFS_STAT: r[rtc_pkg::EV_W-1:0] = stat_q;
      rtc_pkg::OFS_EN: r[rtc_pkg::EV_W-1:0] = en_q;
      default: r = '0;
    endcase
    return r;
  endfunction : reg_read

  function automatic logic mapped(input logic [rtc_pkg::ADDR_W-1:0] a);
    return (a == rtc_pkg::OFS_CTRL) || (a == rtc_pkg::OFS_TIME) || (a == rtc_pkg::OFS_DAY)
      || (a == rtc_pkg::OFS_AL0_TIME) || (a == rtc_pkg::OFS_AL1_TIME)
      || (a == rtc_pkg::OFS_AL1_DAY) || (a == rtc_pkg::OFS_SW)
      || (a == rtc_pkg::OFS_STAT) || (a == rtc_pkg::OFS_CLR) || (a == rtc_pkg::OFS_EN);
  endfunction : mapped

  // crystal pin: the filtered level only moves once the last two stages agree
  always_comb
  begin
    xf_d = (x2_q == x3_q) ? x3_q : xf_q;
    xtal_rise = (x2_q == x3_q) && x3_q && !xf_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      x1_q <= 1'b0;
      x2_q <= 1'b0;
      x3_q <= 1'b0;
      xf_q <= 1'b0;
    end
    else if (ce)
    begin
      x1_q <= xtal_in;
      x2_q <= x1_q;
      x3_q <= x2_q;
      xf_q <= xf_d;
    end
  end

  always_comb
  begin
    pre_d = pre_q;
    calib_d = calib_q;
    run_d = run_q;
    now_d = now_q;
    al0_d = al0_q;
    al1_d = al1_q;
    sw_d = sw_q;
    sw_run_d = sw_run_q;
    en_d = en_q;
    ev = '0;
    clr = '0;
    wv = '0;
    tick = 1'b0;
    half = 1'b0;
    awready_d = awready_q;
    wready_d = wready_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    wa_d = wa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    // only aclk, a high ce, the run bit and the crystal are needed, so the count survives core sleep
    if (run_q && xtal_rise)
    begin
      tick = (pre_q == PRE_LAST);
      half = (pre_q == PRE_HALF);
      pre_d = tick ? '0 : pre_q + 1'b1;
    end
    if (tick || half)
      calib_d = !calib_q;
    if (tick)
    begin
      ev[rtc_pkg::EV_SEC] = 1'b1;
      now_d.tod.sec = now_q.tod.sec + 6'h01;
      // out-of-range software values fold back when their field next advances
      if (now_q.tod.sec >= rtc_pkg::SEC_MAX)
      begin
        now_d.tod.sec = '0;
        now_d.tod.min = now_q.tod.min + 6'h01;
        ev[rtc_pkg::EV_MIN] = 1'b1;
        if (now_q.tod.min >= rtc_pkg::MIN_MAX)
        begin
          now_d.tod.min = '0;
          now_d.tod.hour = now_q.tod.hour + 5'h01;
          ev[rtc_pkg::EV_HOUR] = 1'b1;
          if (now_q.tod.hour >= rtc_pkg::HOUR_MAX)
          begin
            now_d.tod.hour = '0;
            now_d.day = now_q.day + 15'h0001;
            ev[rtc_pkg::EV_DAY] = 1'b1;
          end
        end
      end
      ev[rtc_pkg::EV_AL0] = (now_d.tod == al0_q);
      ev[rtc_pkg::EV_AL1] = (now_d == al1_q);
      if (sw_run_q)
      begin
        if (sw_q == '0)
        begin
          ev[rtc_pkg::EV_SW] = 1'b1;
          sw_run_d = 1'b0;
        end
        else
          sw_d = sw_q - 16'h0001;
      end
    end
    // write channel: address and data taken in either order
    if (awvalid && awready_q)
    begin
      aw_have_d = 1'b1;
      wa_d = awaddr[rtc_pkg::ADDR_W-1:0];
    end
    if (wvalid && wready_q)
    begin
      w_have_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    wr_fire = aw_have_q && w_have_q && !bvalid_q;
    if (wr_fire)
    begin
      wv = reg_read(wa_q);
      for (int b = 0; b < 4; b++)
        if (ws_q[b])
          wv[8*b +: 8] = wd_q[8*b +: 8];
      // a software write overrides a tick landing in the same cycle
      unique case (wa_q)
        rtc_pkg::OFS_CTRL: run_d = wv[rtc_pkg::CTRL_RUN];
        rtc_pkg::OFS_TIME: now_d.tod = word_tod(wv);
        rtc_pkg::OFS_DAY: now_d.day = wv[rtc_pkg::DAY_W-1:0];
        rtc_pkg::OFS_AL0_TIME: al0_d = word_tod(wv);
        rtc_pkg::OFS_AL1_TIME: al1_d.tod = word_tod(wv);
        rtc_pkg::OFS_AL1_DAY: al1_d.day = wv[rtc_pkg::DAY_W-1:0];
        rtc_pkg::OFS_SW:
        begin
          sw_d = wv[rtc_pkg::SW_W-1:0];
          sw_run_d = 1'b1;
        end
        rtc_pkg::OFS_CLR: clr = wd_q[rtc_pkg::EV_W-1:0] & {rtc_pkg::EV_W{ws_q[0]}};
        rtc_pkg::OFS_EN: en_d = wv[rtc_pkg::EV_W-1:0];
        default: clr = '0;
      endcase
      bresp_d = mapped(wa_q) ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
      bvalid_d = 1'b1;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
    end
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    if (arvalid && arready_q)
    begin
      rdata_d = reg_read(araddr[rtc_pkg::ADDR_W-1:0]);
      rresp_d = mapped(araddr[rtc_pkg::ADDR_W-1:0]) ? rtc_pkg::RESP_OKAY
        : rtc_pkg::RESP_SLVERR;
      rvalid_d = 1'b1;
    end
    if (rvalid_q && rready)
      rvalid_d = 1'b0;
    arready_d = !rvalid_d;
    // a new event outweighs a clear of the same bit
    stat_d = (stat_q & ~clr) | ev;
    irq_d = |(stat_d & en_d);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_q <= '0;
      calib_q <= 1'b0;
      run_q <= rtc_pkg::CTRL_RESET;
      now_q <= '0;
      al0_q <= '0;
      al1_q <= '0;
      sw_q <= '0;
      sw_run_q <= 1'b0;
      stat_q <= '0;
      en_q <= '0;
      irq_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= rtc_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= rtc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      pre_q <= pre_d;
      calib_q <= calib_d;
      run_q <= run_d;
      now_q <= now_d;
      al0_q <= al0_d;
      al1_q <= al1_d;
      sw_q <= sw_d;
      sw_run_q <= sw_run_d;
      stat_q <= stat_d;
      en_q <= en_d;
      irq_q <= irq_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq = irq_q;
  assign one_hz_calib_out = calib_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_pre_wrap: assert property (ce && tick |=> pre_q == '0)
    else $error("prescaler did not restart after tick");
  chk_sec_wrap: assert property (ce && tick && !wr_fire && now_q.tod.sec == rtc_pkg::SEC_MAX
    |=> now_q.tod.sec == '0 && now_q.tod.min != $past(now_q.tod.min))
    else $error("seconds did not wrap into minutes");
  chk_hour_wrap: assert property (ce && tick && !wr_fire && ev[rtc_pkg::EV_DAY]
    |=> now_q.tod == '0 && now_q.day == $past(now_q.day) + 15'h0001)
    else $error("day rollover wrong");
  chk_alarm_sets: assert property (ce && ev[rtc_pkg::EV_AL0] && en_q[rtc_pkg::EV_AL0]
    && !wr_fire |=> stat_q[rtc_pkg::EV_AL0] && irq)
    else $error("alarm match not raised");
  chk_alarm1_day: assert property (ce && tick && now_d.tod == al1_q.tod
    && now_d.day != al1_q.day |-> !ev[rtc_pkg::EV_AL1])
    else $error("second alarm ignored day");
  chk_sw_dec: assert property (ce && tick && sw_run_q && sw_q != '0 && !wr_fire
    |=> sw_q == $past(sw_q) - 16'h0001)
    else $error("stopwatch did not decrement");
  chk_sw_underflow: assert property (ce && tick && sw_run_q && sw_q == '0 && !wr_fire
    |=> !sw_run_q && stat_q[rtc_pkg::EV_SW] ##1 (!ce || sw_q == '0))
    else $error("stopwatch underflow wrong");
  chk_tick_flags: assert property (ce && tick |=> stat_q[rtc_pkg::EV_SEC])
    else $error("second flag not set");
  chk_calib_toggle: assert property (ce && tick |=> one_hz_calib_out != $past(calib_q))
    else $error("calibration pin not toggled");
  chk_sticky_flags: assert property (ce && !wr_fire
    |=> (stat_q & $past(stat_q)) == $past(stat_q))
    else $error("pending flag lost");
  chk_irq_level: assert property (irq == |(stat_q & en_q))
    else $error("irq not equal to enabled pending");
  chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");

  cov_tick: cover property (ce && tick);
  cov_day_roll: cover property (ce && ev[rtc_pkg::EV_DAY]);
  cov_alarm1: cover property (ce && ev[rtc_pkg::EV_AL1]);
  cov_sw_under: cover property (ce && ev[rtc_pkg::EV_SW]);
endmodule : rtc_calendar_alarm_stopwatch

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned DIV = 8;
  localparam int unsigned XH = 8;
  localparam int unsigned TK = DIV * XH * 2;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic xtal_in = 1'b0;
  logic ce = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, one_hz_calib_out;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  always #20 aclk = ~aclk;

  rtc_calendar_alarm_stopwatch #(.PRESCALE_DIV(DIV)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .xtal_in(xtal_in),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq), .one_hz_calib_out(one_hz_calib_out)
  );

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // crystal is made synchronous to aclk so measured periods are exact
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc % XH == XH - 1)
      xtal_in <= ~xtal_in;
    if (cyc == 30000)
    begin
      n_fail++;
      close_out();
    end
  end

  // response watcher: oldest note against what the bus returns
  always @(posedge aclk)
  begin
    if (bvalid === 1'b1 && bready)
      check({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid === 1'b1 && rready)
      check({rresp, rdata}, rq.pop_front());
  end

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] er = rtc_pkg::RESP_OKAY);
    bit ad;
    bit wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(er);
    awaddr <= {26'h0, a};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      ad = ad | (awready === 1'b1);
      wd = wd | (wready === 1'b1);
      awvalid <= !ad;
      wvalid <= !wd;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    // idle edge so a following call never redrives bready in the same step
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e,
                    input logic [1:0] er = rtc_pkg::RESP_OKAY);
    rq.push_back({er, e});
    araddr <= {26'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic wait_irq(output int n);
    n = cyc;
    do @(posedge aclk); while (irq !== 1'b1);
    n = cyc - n;
  endtask : wait_irq

  task automatic wait_cal(input logic v, output int t);
    do @(posedge aclk); while (one_hz_calib_out !== v);
    t = cyc;
  endtask : wait_cal

  initial
  begin
    int n;
    int e;
    int t;
    logic [4:0] h;
    logic [5:0] m;
    logic [5:0] s;
    logic [14:0] d;
    logic [15:0] sw;
    n = $urandom(18775);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    rd(rtc_pkg::OFS_CTRL, 32'h1);
    rd(rtc_pkg::OFS_TIME, 32'h0);
    rd(rtc_pkg::OFS_EN, 32'h0);
    rd(6'h28, 32'h0, rtc_pkg::RESP_SLVERR);
    wr(6'h28, 32'hFFFFFFFF, 4'hF, rtc_pkg::RESP_SLVERR);
    $display("test reset done");
    // one tick from 23:59:59 on the last day carries through every counter
    wr(rtc_pkg::OFS_CTRL, 32'h0);
    wr(rtc_pkg::OFS_TIME, 32'h00173B3B);
    wr(rtc_pkg::OFS_DAY, 32'h7FFF);
    wr(rtc_pkg::OFS_CLR, 32'h7F);
    wr(rtc_pkg::OFS_EN, 32'h1);
    wr(rtc_pkg::OFS_CTRL, 32'h1);
    wait_irq(n);
    wr(rtc_pkg::OFS_CTRL, 32'h0);
    rd(rtc_pkg::OFS_TIME, 32'h0);
    rd(rtc_pkg::OFS_DAY, 32'h0);
    // both alarms still hold zero, so the midnight roll matches them as well
    rd(rtc_pkg::OFS_STAT, 32'h3F);
    wr(rtc_pkg::OFS_EN, 32'h0);
    check({33'h0, irq}, 34'h0);
    wr(rtc_pkg::OFS_EN, 32'h1);
    check({33'h0, irq}, 34'h1);
    wr(rtc_pkg::OFS_CLR, 32'h0F);
    check({33'h0, irq}, 34'h0);
    $display("test cascade done");
    wr(rtc_pkg::OFS_CTRL, 32'h1);
    wait_cal(1'b0, t);
    wait_cal(1'b1, n);
    wait_cal(1'b0, e);
    wait_cal(1'b1, t);
    check(34'(e - n), 34'(TK / 2));
    check(34'(t - n), 34'(TK));
    // a low enable freezes the divider, so the pin must not move for a whole tick
    e = int'(one_hz_calib_out);
    ce <= 1'b0;
    repeat (TK) @(posedge aclk);
    check({33'h0, one_hz_calib_out}, 34'(e));
    ce <= 1'b1;
    $display("test calibration done");
    for (int k = 0; k < 2; k++)
    begin
      h = 5'($urandom_range(23));
      m = 6'($urandom_range(59));
      s = 6'($urandom_range(57));
      d = 15'($urandom());
      wr(rtc_pkg::OFS_CTRL, 32'h0);
      wr(rtc_pkg::OFS_TIME, {11'h0, h, 2'h0, m, 2'h0, s});
      wr(rtc_pkg::OFS_DAY, {17'h0, d});
      wr(rtc_pkg::OFS_AL0_TIME, {11'h0, h, 2'h0, m, 2'h0, s + 6'(k + 1)});
      wr(rtc_pkg::OFS_AL1_TIME, {11'h0, h, 2'h0, m, 2'h0, s + 6'h1});
      wr(rtc_pkg::OFS_AL1_DAY, {17'h0, d + 15'(1 - k)});
      wr(rtc_pkg::OFS_CLR, 32'h7F);
      wr(rtc_pkg::OFS_EN, 32'h30);
      wr(rtc_pkg::OFS_CTRL, 32'h1);
      wait_irq(n);
      wr(rtc_pkg::OFS_CTRL, 32'h0);
      rd(rtc_pkg::OFS_STAT, (k == 1) ? 32'h21 : 32'h11);
    end
    $display("test alarms done");
    sw = 16'($urandom_range(3));
    wr(rtc_pkg::OFS_CLR, 32'h7F);
    wr(rtc_pkg::OFS_EN, 32'h40);
    wr(rtc_pkg::OFS_SW, {16'h0, sw});
    rd(rtc_pkg::OFS_SW, {15'h0, 1'b1, sw});
    wr(rtc_pkg::OFS_CTRL, 32'h1);
    wait_irq(n);
    check(34'(n + 8 > sw * TK && n <= (sw + 1) * TK + 16), 34'h1);
    repeat (2 * TK) @(posedge aclk);
    wr(rtc_pkg::OFS_CTRL, 32'h0);
    rd(rtc_pkg::OFS_SW, 32'h0);
    wr(rtc_pkg::OFS_SW, 32'h5);
    rd(rtc_pkg::OFS_SW, 32'h10005);
    $display("test stopwatch done");
    wr(rtc_pkg::OFS_DAY, 32'h1234);
    wr(rtc_pkg::OFS_DAY, 32'h5600, 4'h2);
    rd(rtc_pkg::OFS_DAY, 32'h5634);
    rd(rtc_pkg::OFS_CLR, 32'h0);
    wr(rtc_pkg::OFS_CLR, 32'h3F);
    wr(rtc_pkg::OFS_STAT, 32'h0);
    rd(rtc_pkg::OFS_STAT, 32'h40);
    $display("test register access done");
    close_out();
  end
endmodule : tb_top
